// ===== design/cgm_pkg.sv
/*
 * constants for the clock generator mode control block: register map,
 * field positions, mode codes, state encoding and timing counts.
 * assumes a 200 MHz bus clock and a 32-bit AHB-Lite register bus.
 */
package cgm_pkg;
    // ***************************************************************
    // register map, one aligned word each
    // ***************************************************************
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_STAT1 = 8'h08;
    localparam logic [7:0] OFS_STAT2 = 8'h0C;
    localparam logic [7:0] OFS_FLTU = 8'h10;
    localparam logic [7:0] OFS_FLTL = 8'h14;
    localparam logic [7:0] OFS_TRIM = 8'h18;
    localparam logic [7:0] FLTU_MASK = 8'h0F;
    localparam logic [7:0] REG_RST = 8'h00;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int HGO_BIT = 7;
    localparam int RANGE_BIT = 6;
    localparam int REFERENCE_SELECT_BIT = 5;
    localparam int CLOCK_MODE_SELECT_HI = 4;
    localparam int CLOCK_MODE_SELECT_LO = 3;
    localparam int OSCST_BIT = 2;
    localparam int LOSS_OF_CLOCK_DISABLE_BIT = 1;
    localparam int REFERENCE_TYPE_STATUS_BIT = 5;
    localparam int LOCK_BIT = 3;
    localparam int EXT_REF_CLOCK_VALID_BIT = 1;
    localparam int DCOS_BIT = 0;

    // ***************************************************************
    // clock mode codes and loop prescale factors
    // ***************************************************************
    localparam logic [1:0] MODE_SCM = 2'h0;
    localparam logic [1:0] MODE_FEI = 2'h1;
    localparam logic [1:0] MODE_FBE = 2'h2;
    localparam logic [1:0] MODE_FEE = 2'h3;
    localparam logic [6:0] PRESCALE_LOW = 7'h40;
    localparam logic [6:0] PRESCALE_HIGH = 7'h01;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LOCK_TIME_NS = 2000;
    localparam int LOCK_CYC = (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOC_TIMEOUT_NS = 1000;
    localparam int LOC_CYC = (LOC_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    localparam int SYNC_CYC = 4;
    localparam int VALID_EDGES = 4;

    typedef enum logic [2:0] {
        ST_OFF, ST_SCM, ST_FEI_UNLK, ST_FEI_LK, ST_FBE, ST_FEE_UNLK, ST_FEE_LK
    } cgm_state_e;
endpackage : cgm_pkg

// ===== design/cgm_ctrl.sv
/*
 * clock generator mode control: control register 1 with write-once fields,
 * mode state machine, external reference monitor and an AHB-Lite slave.
 * assumes stop_req comes from the cpu on hclk; ext_ref_input_pin is async.
 */
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
// What this block does
// R1: stop request puts the generator in off mode with its output clock static.
// R2: after reset the generator starts in self-clocked mode, loop open.
// R3: internal loop mode passes unlocked state, then locked once lock is detected.
// R4: bypassed external mode uses the external clock directly as source.
// R5: external loop mode passes unlocked state before reaching locked.
// R6: first control-1 write decides whether the reference input pin is used.
// R7: first write choosing external mode reserves the oscillator output pin.
// R8: bit 7 selects low power or high gain, writable once.
// R9: write-once bits ignore all later writes until the next reset.
// R10: bit 6 selects low range, prescale 64, or high range, prescale 1.
// R11: range matters only in the two external-reference modes.
// R12: bit 5 picks external square wave (0) or crystal oscillator (1).
// R13: mode field bits 4:3: 00 self, 01 int loop, 10 bypass, 11 ext loop.
// R14: bypassed external mode waits until the external clock is valid.
// R15: entering off mode leaves the mode select field unchanged.
// R16: mode writes are ignored while a previous mode write is completing.
// R17: if first write picked 0X, later writes of 1X are blocked.
// R18: oscillator kept running in off mode per enable bit, mode and reference.
// R19: oscillator-in-off bit has no effect when gain and range are both 1.
// R20: bit 1 disables loss-of-clock detection when set.
// R21: mode status shows the mode in effect, lagging writes by synchronisation.
// R22: a per-reset marker records that control register 1 has been written.
// R23: unused bit 0 of control register 1 reads as zero.
`timescale 1ns/10ps
module cgm_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic stop_req,
    input wire logic osc_stop_enable,
    input wire logic ext_ref_input_pin,
    output logic generator_output_static,
    output logic [1:0] clock_mode_status,
    output logic fll_locked,
    output logic ext_ref_clock_valid,
    output logic ext_ref_pin_used,
    output logic ext_ref_pin_is_osc,
    output logic osc_output_pin_used,
    output logic osc_enable,
    output logic osc_high_gain,
    output logic [6:0] loop_prescale,
    output logic loss_of_clock_det_en,
    output logic [7:0] gen_control_2,
    output logic [11:0] loop_filter,
    output logic [7:0] ref_trim
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ***************************************************************
    // bus slave
    // ***************************************************************
    logic rd_ff, wr_ff, rdy_ff, hit_ff;
    logic [7:0] addr_ff;
    logic [31:0] rdata_ff;
    logic acc;
    logic [7:0] rd_mux;
    logic [7:0] wd;

    assign acc = hsel & htrans[1] & hready;
    assign wd = hwdata[7:0];
    // reads take one wait state so a write just before is visible
    assign hreadyout = !(rd_ff & !rdy_ff);
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;

    // address phase capture and read wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            rdy_ff <= 1'b0;
            hit_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else if (hreadyout) begin
            rd_ff <= acc & !hwrite;
            wr_ff <= acc & hwrite;
            rdy_ff <= 1'b0;
            hit_ff <= (haddr[31:8] == 24'h000000);
            addr_ff <= haddr[7:0];
        end else begin
            rdy_ff <= 1'b1;
        end
    end

    // read data register, loaded in the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_ff && !rdy_ff) begin
            rdata_ff <= {24'h000000, hit_ff ? rd_mux : 8'h00};
        end
    end
    logic we;
    assign we = wr_ff & hit_ff;

    // ***************************************************************
    // control register 1
    // ***************************************************************
    logic written_ff, pins_res_ff, hgo_ff, range_ff, reference_select_ff, osc_keep_in_off_ff, loss_of_clock_disable_ff;
    logic [1:0] clock_mode_select_ff, appl_mode_ff;
    logic pending_ff;
    logic [2:0] sync_cnt_ff;
    logic clock_mode_select_ok;
    logic we_c1;

    assign we_c1 = we && (addr_ff == cgm_pkg::OFS_CTRL1);
    // 1X only if the pins were reserved (or are reserved by this write)
    assign clock_mode_select_ok = !pending_ff && // R16
        (!wd[cgm_pkg::CLOCK_MODE_SELECT_HI] || (written_ff ? pins_res_ff : 1'b1)); // R17

    // write-once fields and pin reservation, latched by the first write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            written_ff <= 1'b0;
            pins_res_ff <= 1'b0;
            hgo_ff <= 1'b0;
            range_ff <= 1'b0;
            reference_select_ff <= 1'b0;
        end else if (we_c1 && !written_ff) begin // R9 R22
            written_ff <= 1'b1;
            pins_res_ff <= wd[cgm_pkg::CLOCK_MODE_SELECT_HI]; // R6 R7
            hgo_ff <= wd[cgm_pkg::HGO_BIT]; // R8
            range_ff <= wd[cgm_pkg::RANGE_BIT]; // R10
            reference_select_ff <= wd[cgm_pkg::REFERENCE_SELECT_BIT]; // R12
        end
    end

    // freely writable bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_keep_in_off_ff <= 1'b0;
            loss_of_clock_disable_ff <= 1'b0;
        end else if (we_c1) begin
            osc_keep_in_off_ff <= wd[cgm_pkg::OSCST_BIT];
            loss_of_clock_disable_ff <= wd[cgm_pkg::LOSS_OF_CLOCK_DISABLE_BIT];
        end
    end

    // mode select and its synchronisation into the mode logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_mode_select_ff <= cgm_pkg::MODE_SCM;
            appl_mode_ff <= cgm_pkg::MODE_SCM;
            pending_ff <= 1'b0;
            sync_cnt_ff <= 3'h0;
        end else if (we_c1 && clock_mode_select_ok) begin
            clock_mode_select_ff <= wd[cgm_pkg::CLOCK_MODE_SELECT_HI:cgm_pkg::CLOCK_MODE_SELECT_LO]; // R13
            pending_ff <= 1'b1;
            sync_cnt_ff <= 3'h0;
        end else if (pending_ff) begin
            sync_cnt_ff <= sync_cnt_ff + 3'h1;
            if (sync_cnt_ff == 3'(cgm_pkg::SYNC_CYC - 1)) begin
                appl_mode_ff <= clock_mode_select_ff; // R21
                pending_ff <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // other registers, plain storage driving the outputs
    // ***************************************************************
    logic [7:0] c2_ff, fltu_ff, fltl_ff, trim_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c2_ff <= cgm_pkg::REG_RST;
            fltu_ff <= cgm_pkg::REG_RST;
            fltl_ff <= cgm_pkg::REG_RST;
            trim_ff <= cgm_pkg::REG_RST;
        end else if (we) begin
            if (addr_ff == cgm_pkg::OFS_CTRL2) c2_ff <= wd;
            if (addr_ff == cgm_pkg::OFS_FLTU) fltu_ff <= wd & cgm_pkg::FLTU_MASK;
            if (addr_ff == cgm_pkg::OFS_FLTL) fltl_ff <= wd;
            if (addr_ff == cgm_pkg::OFS_TRIM) trim_ff <= wd;
        end
    end

    // ***************************************************************
    // external reference monitor
    // ***************************************************************
    logic ext_s1_ff, ext_s2_ff, ext_s3_ff, ext_lvl_ff, ext_valid_ff;
    logic [7:0] gap_ff;
    logic [2:0] edges_ff;
    logic ext_rise;

    // three-stage synchroniser, level accepted when stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
            ext_lvl_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_ref_input_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
            if (ext_s2_ff == ext_s3_ff) ext_lvl_ff <= ext_s3_ff;
        end
    end

    assign ext_rise = (ext_s2_ff == ext_s3_ff) && ext_s3_ff && !ext_lvl_ff;
    // valid after a few edges, lost when no edge within the timeout
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff <= 8'h00;
            edges_ff <= 3'h0;
            ext_valid_ff <= 1'b0;
        end else if (!pins_res_ff) begin // R6
            gap_ff <= 8'h00;
            edges_ff <= 3'h0;
            ext_valid_ff <= 1'b0;
        end else if (ext_rise) begin
            gap_ff <= 8'h00;
            if (edges_ff == 3'(cgm_pkg::VALID_EDGES - 1)) ext_valid_ff <= 1'b1;
            else edges_ff <= edges_ff + 3'h1;
        end else if (gap_ff == 8'(cgm_pkg::LOC_CYC - 1)) begin
            edges_ff <= 3'h0;
            ext_valid_ff <= 1'b0;
        end else begin
            gap_ff <= gap_ff + 8'h01;
        end
    end

    // ***************************************************************
    // mode state machine
    // ***************************************************************
    cgm_pkg::cgm_state_e state_ff, nxt_state;
    logic [8:0] lock_cnt_ff;
    logic lock_done;

    assign lock_done = lock_cnt_ff == 9'(cgm_pkg::LOCK_CYC - 1);

    // state follows the applied mode; clock_mode_select_ff is never touched here
    always_comb begin
        nxt_state = state_ff;
        if (stop_req) begin
            nxt_state = cgm_pkg::ST_OFF; // R1 R15
        end else begin
            case (appl_mode_ff)
                cgm_pkg::MODE_FEI: begin // R3
                    if (state_ff == cgm_pkg::ST_FEI_UNLK && lock_done) begin
                        nxt_state = cgm_pkg::ST_FEI_LK;
                    end else if (state_ff != cgm_pkg::ST_FEI_LK) begin
                        nxt_state = cgm_pkg::ST_FEI_UNLK;
                    end
                end
                cgm_pkg::MODE_FBE: begin // R4
                    if (ext_valid_ff) nxt_state = cgm_pkg::ST_FBE; // R14
                    else if (state_ff == cgm_pkg::ST_OFF) nxt_state = cgm_pkg::ST_SCM;
                end
                cgm_pkg::MODE_FEE: begin // R5
                    if (!ext_valid_ff) begin
                        nxt_state = cgm_pkg::ST_FEE_UNLK;
                    end else if (state_ff == cgm_pkg::ST_FEE_UNLK && lock_done) begin
                        nxt_state = cgm_pkg::ST_FEE_LK;
                    end else if (state_ff != cgm_pkg::ST_FEE_LK) begin
                        nxt_state = cgm_pkg::ST_FEE_UNLK;
                    end
                end
                default: nxt_state = cgm_pkg::ST_SCM; // R2
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) state_ff <= cgm_pkg::ST_SCM; // R2
        else state_ff <= nxt_state;
    end

    // lock detector stand-in: a settle time spent in the unlocked state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_cnt_ff <= 9'h000;
        end else if ((state_ff == cgm_pkg::ST_FEI_UNLK || state_ff == cgm_pkg::ST_FEE_UNLK)
                     && !lock_done) begin
            lock_cnt_ff <= lock_cnt_ff + 9'h001;
        end else if (state_ff != cgm_pkg::ST_FEI_UNLK && state_ff != cgm_pkg::ST_FEE_UNLK) begin
            lock_cnt_ff <= 9'h000;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    logic osc_run, osc_off;

    always_comb begin
        case (state_ff)
            cgm_pkg::ST_FEI_UNLK, cgm_pkg::ST_FEI_LK: clock_mode_status = cgm_pkg::MODE_FEI;
            cgm_pkg::ST_FBE: clock_mode_status = cgm_pkg::MODE_FBE;
            cgm_pkg::ST_FEE_UNLK, cgm_pkg::ST_FEE_LK: clock_mode_status = cgm_pkg::MODE_FEE;
            cgm_pkg::ST_OFF: clock_mode_status = appl_mode_ff;
            default: clock_mode_status = cgm_pkg::MODE_SCM;
        endcase
    end

    assign generator_output_static = (state_ff == cgm_pkg::ST_OFF); // R1
    assign fll_locked = (state_ff == cgm_pkg::ST_FEI_LK) || (state_ff == cgm_pkg::ST_FEE_LK);
    assign ext_ref_clock_valid = ext_valid_ff;
    assign ext_ref_pin_used = pins_res_ff; // R6
    assign ext_ref_pin_is_osc = pins_res_ff & reference_select_ff; // R6 R12
    assign osc_output_pin_used = pins_res_ff; // R7
    assign osc_high_gain = hgo_ff; // R8
    // range only counts in the external modes; low range is the default
    assign loop_prescale = (range_ff && clock_mode_status[1]) ? // R11
        cgm_pkg::PRESCALE_HIGH : cgm_pkg::PRESCALE_LOW; // R10
    assign loss_of_clock_det_en = !loss_of_clock_disable_ff; // R20
    assign gen_control_2 = c2_ff;
    assign loop_filter = {fltu_ff[3:0], fltl_ff};
    assign ref_trim = trim_ff;

    // outside off mode the oscillator runs whenever the pins are reserved for the crystal
    assign osc_run = pins_res_ff & reference_select_ff;
    always_comb begin
        if (hgo_ff && range_ff) osc_off = osc_run; // R19
        else if (osc_keep_in_off_ff) osc_off = clock_mode_select_ff[1] & osc_run; // R18
        else osc_off = osc_stop_enable & (clock_mode_select_ff == cgm_pkg::MODE_FBE) & osc_run; // R18
    end
    assign osc_enable = (state_ff == cgm_pkg::ST_OFF) ? osc_off : osc_run;

    always_comb begin
        case (addr_ff)
            cgm_pkg::OFS_CTRL1: rd_mux = {hgo_ff, range_ff, reference_select_ff, clock_mode_select_ff, osc_keep_in_off_ff,
                                          loss_of_clock_disable_ff, 1'b0}; // R23
            cgm_pkg::OFS_CTRL2: rd_mux = c2_ff;
            cgm_pkg::OFS_STAT1: rd_mux = {clock_mode_status, reference_select_ff, 1'b0, fll_locked,
                                          1'b0, ext_valid_ff, 1'b0};
            cgm_pkg::OFS_STAT2: rd_mux = {7'h00, fll_locked};
            cgm_pkg::OFS_FLTU: rd_mux = fltu_ff;
            cgm_pkg::OFS_FLTL: rd_mux = fltl_ff;
            cgm_pkg::OFS_TRIM: rd_mux = trim_ff;
            default: rd_mux = 8'h00;
        endcase
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    property p_off;
        stop_req |=> generator_output_static;
    endproperty
    a_off: assert property (p_off) else $error("stop did not stop the clock"); // R1
    property p_scm;
        !written_ff |-> clock_mode_status == cgm_pkg::MODE_SCM;
    endproperty
    a_scm: assert property (p_scm) else $error("left self-clocked before a write"); // R2
    property p_lock;
        state_ff == cgm_pkg::ST_FEI_UNLK && lock_done && !stop_req
            && appl_mode_ff == cgm_pkg::MODE_FEI |=> state_ff == cgm_pkg::ST_FEI_LK;
    endproperty
    a_lock: assert property (p_lock) else $error("no lock after settle time"); // R3
    property p_fbe;
        state_ff == cgm_pkg::ST_FBE && $past(state_ff) != cgm_pkg::ST_FBE
            |-> $past(ext_valid_ff);
    endproperty
    a_fbe: assert property (p_fbe) else $error("bypass entered without valid clock"); // R14
    property p_once;
        written_ff |=> $stable(hgo_ff) && $stable(range_ff) && $stable(reference_select_ff);
    endproperty
    a_once: assert property (p_once) else $error("write-once bit changed"); // R9
    property p_block;
        written_ff && !pins_res_ff |-> !clock_mode_select_ff[1];
    endproperty
    a_block: assert property (p_block) else $error("1X mode without reserved pins"); // R17
    property p_pend;
        pending_ff |=> $stable(clock_mode_select_ff);
    endproperty
    a_pend: assert property (p_pend) else $error("mode write taken while pending"); // R16
    property p_lag;
        $changed(clock_mode_select_ff) |-> ##4 appl_mode_ff == clock_mode_select_ff;
    endproperty
    a_lag: assert property (p_lag) else $error("mode not applied after sync"); // R21
    property p_bit0;
        rd_ff && !rdy_ff && addr_ff == cgm_pkg::OFS_CTRL1 |=> hrdata[0] == 1'b0;
    endproperty
    a_bit0: assert property (p_bit0) else $error("control 1 bit 0 read nonzero"); // R23
    property p_oscoff;
        state_ff == cgm_pkg::ST_OFF && !(hgo_ff && range_ff) && osc_keep_in_off_ff
            && clock_mode_select_ff[1] && pins_res_ff && reference_select_ff |-> osc_enable;
    endproperty
    a_oscoff: assert property (p_oscoff) else $error("oscillator off in off mode"); // R18
endmodule : cgm_ctrl

// ===== tb/cgm_ext_src.sv
/*
 * external square-wave reference source for the clock generator bench.
 * assumes the bench raises run only while a clock is wanted on the pin.
 */
`timescale 1ns/10ps
module cgm_ext_src (
    input wire logic run,
    output logic clk
);
    // ********
    // source
    // ********
    // 160 ns period; held low while stopped so the monitor sees no stray edge
    initial clk = 1'b0;
    always begin
        if (run) begin
            #80 clk = 1'b1;
            #80 clk = 1'b0;
        end else begin
            #5;
        end
    end
endmodule : cgm_ext_src

// ===== tb/cgm_ctrl_tb_top.sv
/*
 * self-checking bench for cgm_ctrl: AHB-Lite master tasks, a register
 * model in integers and an external square-wave source.
 * assumes cgm_pkg and cgm_ext_src are compiled first.
 */
`timescale 1ns/10ps
module cgm_ctrl_tb_top;
    // ********
    // signals and design
    // ********
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic stop_req = 1'b0, ext_run = 1'b0, osc_keep = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    logic [31:0] seed = 32'h555980BA;
    logic [1:0] htrans = 2'h0, mode_st;
    logic hreadyout, hresp, ext_pin, out_static, locked, ext_valid, pin_used, pin_osc;
    logic osc_pin, osc_en, high_gain, lc_en;
    logic [6:0] prescale;
    logic [7:0] ctrl2_q, trim_q;
    logic [11:0] filt_q;
    int fails = 0, n_compared = 0, m_first, m_low, n;
    int m_reg[8];
    int ix[4] = '{1, 4, 5, 6};
    time m_t;

    always #2.5 hclk = ~hclk;

    cgm_ctrl i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stop_req(stop_req),
        .osc_stop_enable(osc_keep), .ext_ref_input_pin(ext_pin),
        .generator_output_static(out_static), .clock_mode_status(mode_st),
        .fll_locked(locked), .ext_ref_clock_valid(ext_valid), .ext_ref_pin_used(pin_used),
        .ext_ref_pin_is_osc(pin_osc), .osc_output_pin_used(osc_pin), .osc_enable(osc_en),
        .osc_high_gain(high_gain), .loop_prescale(prescale), .loss_of_clock_det_en(lc_en),
        .gen_control_2(ctrl2_q), .loop_filter(filt_q), .ref_trim(trim_q)
    );
    cgm_ext_src i_src (.run(ext_run), .clk(ext_pin));

    // ********
    // checking and model
    // ********
    task automatic note(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : note
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        note(got, exp);
    endtask : cmp_rd
    task automatic cmp_pin(input logic [11:0] got, input logic [11:0] exp);
        note({20'h0, got}, {20'h0, exp});
    endtask : cmp_pin
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
    endtask : tick
    // a wait loop that ran out of its bound ends the run as a failure
    task automatic limit(input int k, input int lim);
        if (k >= lim) begin
            fails++;
            stop_test();
        end
    endtask : limit
    // model: write-once fields frozen after the first write, mode guards
    task automatic mdl_wr(input int idx, input int d);
        int c;
        c = (d >> 3) & 3;
        if (idx != 0) begin
            m_reg[idx] = d & (idx == 4 ? 8'h0F : 8'hFF);
        end else if (m_first == 0) begin
            m_reg[0] = d & 8'hFE;
            m_first = 1;
            m_low = c < 2;
            m_t = $time;
        end else begin
            // a blocked mode write still lands its other bits
            if ($time - m_t <= cgm_pkg::SYNC_CYC * 5 || (m_low != 0 && c > 1)) begin
                c = (m_reg[0] >> 3) & 3;
            end else begin
                m_t = $time;
            end
            m_reg[0] = (m_reg[0] & 8'hE0) | (d & 8'h06) | (c << 3);
        end
    endtask : mdl_wr
    task automatic mdl_reset;
        m_reg = '{default: 0};
        m_first = 0;
    endtask : mdl_reset

    // ********
    // bus master
    // ********
    // one single transfer; no wait count assumed, bounded by a timeout
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 50);
            if (n >= 50) begin
                fails++;
                stop_test();
            end
            if (k == 0) begin
                htrans <= 2'h0;
                hsel <= 1'b0;
                hwdata <= d;
            end
        end
        rdat = hrdata;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input int d);
        xfer(a, 1'b1, d);
        if (a < 32'h20) begin
            mdl_wr(int'(a) / 4, d);
        end
    endtask : wr
    task automatic rd(input logic [31:0] a, input int e);
        xfer(a, 1'b0, 32'h0);
        cmp_rd(rdat, e);
    endtask : rd

    // ********
    // scenarios
    // ********
    initial begin
        mdl_reset();
        tick(8);
        hresetn <= 1'b1;
        rd(32'h0, 0);
        rd(32'h8, 0);
        cmp_pin(12'(lc_en), 12'h1);
        wr(32'h0, 32'hF3);
        rd(32'h0, m_reg[0]);
        cmp_pin(12'({pin_used, osc_pin, pin_osc, high_gain}), 12'hF);
        cmp_pin(12'(lc_en), 12'h0);
        tick(20);
        rd(32'h8, 32'h20);
        ext_run <= 1'b1;
        for (n = 0; n < 300 && ext_valid !== 1'b1; n++) begin
            tick(1);
        end
        limit(n, 300);
        tick(10);
        rd(32'h8, 32'hA2);
        cmp_pin(12'(prescale), 12'h1);
        // off mode keeps the oscillator: gain and range both set
        stop_req <= 1'b1;
        tick(3);
        cmp_pin(12'({out_static, osc_en}), 12'h3);
        rd(32'h0, m_reg[0]);
        stop_req <= 1'b0;
        tick(10);
        wr(32'h0, 32'h0);
        wr(32'h0, 32'h18);
        rd(32'h0, m_reg[0]);
        tick(10);
        rd(32'h8, 32'h22);
        foreach (ix[j]) begin
            seed = lfsr(seed);
            wr(ix[j] * 4, int'(seed[7:0]));
            rd(ix[j] * 4, m_reg[ix[j]]);
        end
        cmp_pin({4'h0, ctrl2_q}, 12'(m_reg[1]));
        cmp_pin(filt_q, 12'((m_reg[4] << 8) | m_reg[5]));
        cmp_pin({4'h0, trim_q}, 12'(m_reg[6]));
        wr(32'h100, 32'hFF);
        rd(32'h100, 0);
        rd(32'h4, m_reg[1]);
        // second reset: internal mode first, so the pins stay free
        hresetn <= 1'b0;
        ext_run <= 1'b0;
        mdl_reset();
        tick(3);
        hresetn <= 1'b1;
        tick(1);
        wr(32'h0, 32'h48);
        tick(10);
        cmp_pin(12'({locked, pin_used, osc_pin}), 12'h0);
        cmp_pin(12'(prescale), 12'h40);
        for (n = 0; n < 600 && locked !== 1'b1; n++) begin
            tick(1);
        end
        limit(n, 600);
        cmp_pin(12'({mode_st, locked}), 12'h3);
        wr(32'h0, 32'h10);
        tick(10);
        rd(32'h0, m_reg[0]);
        // third reset: crystal, external loop, oscillator kept in off mode
        hresetn <= 1'b0;
        mdl_reset();
        tick(3);
        hresetn <= 1'b1;
        tick(1);
        wr(32'h0, 32'h3C);
        ext_run <= 1'b1;
        for (n = 0; n < 900 && locked !== 1'b1; n++) begin
            tick(1);
        end
        limit(n, 900);
        cmp_pin(12'({mode_st, locked, prescale}), 12'h3C0);
        cmp_pin(12'({hresp, ext_valid, pin_osc}), 12'h3);
        rd(32'h8, 32'hEA);
        rd(32'hC, 32'h1);
        stop_req <= 1'b1;
        tick(2);
        cmp_pin(12'({out_static, osc_en}), 12'h3);
        wr(32'h0, 32'h10);
        rd(32'h0, m_reg[0]);
        cmp_pin(12'(osc_en), 12'h0);
        osc_keep <= 1'b1;
        tick(1);
        cmp_pin(12'(osc_en), 12'h1);
        stop_req <= 1'b0;
        stop_test();
    end
endmodule : cgm_ctrl_tb_top
